// ### shared/cmp_regs.vh
// Purpose: Register offsets, field positions and reset values of the comparator control block.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes:   Channel n registers sit at base 8'h00 + 4*n.
`ifndef CMP_REGS_VH
`define CMP_REGS_VH
`define CMP_ADDR_W          8
`define CMP_CH_STRIDE       8'h04
`define CMP_OFF_MAIN        8'h00
`define CMP_OFF_EDGE        8'h01
`define CMP_OFF_NSEL        8'h02
`define CMP_OFF_PSEL        8'h03
`define CMP_OFF_MIRROR      8'h10
`define CMP_OFF_FLAGS       8'h11
`define CMP_OFF_IRQEN       8'h12
`define CMP_BIT_ENABLE      7
`define CMP_BIT_RESULT      6
`define CMP_BIT_INVERT      4
`define CMP_BIT_FIXED_ONE   2
`define CMP_BIT_HYST        1
`define CMP_BIT_SYNC        0
`define CMP_BIT_RISE        1
`define CMP_BIT_FALL        0
`define CMP_NSEL_GND        3'h7
`define CMP_NSEL_FIXREF     3'h6
`define CMP_NSEL_NC_HI      3'h5
`define CMP_NSEL_NC_LO      3'h4
`define CMP_PSEL_GND        3'h7
`define CMP_PSEL_FIXREF     3'h6
`define CMP_PSEL_DAC        3'h5
`define CMP_PSEL_PIN1       3'h1
`define CMP_PSEL_PIN0       3'h0
`define CMP_SEL_RESET       3'h0
`endif

// ### verification/analog_comparator_control_checker.sv
// Purpose: Port-level assertions for the comparator control block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Write effects get one extra cycle for output registers.
module analog_comparator_control_checker (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [1:0]  power_enable_o,
  input wire logic [1:0]  hysteresis_enable_o,
  input wire logic [15:0] nmux_o,
  input wire logic [15:0] pmux_o,
  input wire logic        sleep_i,
  input wire logic        conversion_start_o,
  input wire logic        timer_reset_o,
  input wire logic [1:0]  cmp_irq_flag_o,
  input wire logic        wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_mirror_upper: assert property (read_i && addr_i == 8'h10 |=> rdata_o[7:2] == 6'h00)
    else $error("mirror upper bits not zero");
  a_enable_follow: assert property ((write_i && addr_i == 8'h00 && wdata_i[7]) ##1 !write_i
    |-> ##[0:1] power_enable_o[0])
    else $error("power enable did not follow");
  a_hyst_follow: assert property ((write_i && addr_i == 8'h00 && wdata_i[1]) ##1 !write_i
    |-> ##[0:1] hysteresis_enable_o[0])
    else $error("hysteresis enable did not follow");
  a_nsel_gap: assert property (nmux_o[5:4] == 2'b00 && nmux_o[13:12] == 2'b00)
    else $error("inverting mux on a no-connect code");
  a_psel_gap: assert property (pmux_o[4:2] == 3'h0 && pmux_o[12:10] == 3'h0)
    else $error("noninverting mux on a no-connect code");
  a_conv_pulse: assert property (conversion_start_o |=> !conversion_start_o)
    else $error("conversion start longer than one cycle");
  a_wake_sleep: assert property ($rose(wake_o) |-> $past(sleep_i))
    else $error("wake raised outside sleep");
  a_flag_hold: assert property ((cmp_irq_flag_o[0] && !write_i) [*2] |=> cmp_irq_flag_o[0])
    else $error("flag dropped without a clear");
  c_conv: cover property (conversion_start_o);
  c_trst: cover property (timer_reset_o);
  c_wake: cover property (wake_o);
endmodule // analog_comparator_control_checker

// ### verification/analog_comparator_control_tb.sv
// Purpose: Register-level scenarios for the comparator control block.
// Assumes: TICK_DIV of 4, so a result settles well within twelve clocks.
// Notes:   Consumer selects stay on channel 0 for the whole run.
module analog_comparator_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, rst_i, write_i, read_i, timer_clk_i, sleep_i;
  logic [7:0]  addr_i, wdata_i;
  logic [1:0]  above, shut_en;
  logic        run_in_sleep;
  wire  [7:0]  rdata_o;
  wire  [15:0] nmux_o, pmux_o;
  wire  [1:0]  raw, power_enable_o, hysteresis_enable_o, pin_out_o, cmp_irq_flag_o;
  wire         shutdown_o, conversion_start_o, timer_reset_o, wake_o;
  int          n_mismatch, tests_run, cycles, n_conv, n_trst;

  analog_comparator_control #(.CHANNELS(2), .TICK_DIV(4)) analog_comparator_control_inst (
    .clock_i, .rst_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o, .raw_i(raw),
    .power_enable_o, .hysteresis_enable_o, .nmux_o, .pmux_o, .timer_clk_i,
    .timer_runs_in_sleep_i(run_in_sleep), .sleep_i, .shutdown_source_enable_i(shut_en),
    .conversion_trigger_select_i(2'b01), .timer_reset_select_i(2'b01), .pin_out_o,
    .shutdown_o, .conversion_start_o, .timer_reset_o, .cmp_irq_flag_o, .wake_o);
  comparator_core_model comparator_core_model_inst (.clock_i, .power_i(power_enable_o),
    .nmux_i(nmux_o), .pmux_i(pmux_o), .above_i(above), .raw_o(raw));

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The ceiling is several times the length of the sequence below.
  always @(posedge clock_i)
  begin
    cycles++;
    if (conversion_start_o === 1'b1) n_conv++;
    if (timer_reset_o === 1'b1) n_trst++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, exp);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, rdata_o);
  endtask

  // Results move only on the instruction tick, so three ticks are allowed.
  task automatic settle();
    repeat (12) @(posedge clock_i);
    #1;
  endtask

  initial
  begin
    {rst_i, write_i, read_i, sleep_i, timer_clk_i} = 5'b10001;
    {addr_i, wdata_i, above} = 18'h0_0000;
    shut_en = 2'b01;
    run_in_sleep = 1'b0;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(8'h00, 8'h04);
    rd(8'h10, 8'h00);
    rd(8'h08, 8'h00);
    wr(8'h02, 8'h04);
    wr(8'h01, 8'h03);
    wr(8'h12, 8'h01);
    above <= 2'b11;
    wr(8'h00, 8'h82);
    settle();
    rd(8'h00, 8'h86);
    chk("nmux", 8'h00, nmux_o[7:0]);
    chk("hys", 8'h01, {6'h00, hysteresis_enable_o});
    wr(8'h02, 8'h00);
    settle();
    rd(8'h00, 8'hC6);
    rd(8'h10, 8'h01);
    chk("pin", 8'h01, {6'h00, pin_out_o});
    chk("conv", 8'h01, 8'(n_conv));
    chk("trst", 8'h01, 8'(n_trst));
    chk("shut", 8'h01, {7'h00, shutdown_o});
    shut_en <= 2'b00;
    repeat (2) @(posedge clock_i);
    #1 chk("shut", 8'h00, {7'h00, shutdown_o});
    shut_en <= 2'b01;
    rd(8'h11, 8'h01);
    wr(8'h11, 8'h01);
    rd(8'h11, 8'h00);
    wr(8'h00, 8'h92);
    settle();
    rd(8'h00, 8'h96);
    chk("shut", 8'h00, {7'h00, shutdown_o});
    rd(8'h11, 8'h01);
    wr(8'h01, 8'h01);
    wr(8'h11, 8'h01);
    wr(8'h00, 8'h82);
    settle();
    rd(8'h11, 8'h00);
    sleep_i <= 1'b1;
    wr(8'h00, 8'h92);
    settle();
    chk("wake", 8'h01, {7'h00, wake_o});
    sleep_i <= 1'b0;
    wr(8'h00, 8'h83);
    timer_clk_i <= 1'b0;
    settle();
    chk("pin", 8'h01, {6'h00, pin_out_o});
    timer_clk_i <= 1'b1;
    above <= 2'b10;
    settle();
    chk("pin", 8'h01, {6'h00, pin_out_o});
    sleep_i <= 1'b1;
    timer_clk_i <= 1'b0;
    settle();
    chk("pin", 8'h01, {6'h00, pin_out_o});
    rd(8'h10, 8'h00);
    run_in_sleep <= 1'b1;
    timer_clk_i <= 1'b1;
    settle();
    timer_clk_i <= 1'b0;
    settle();
    chk("pin", 8'h00, {6'h00, pin_out_o});
    sleep_i <= 1'b0;
    run_in_sleep <= 1'b0;
    wr(8'h11, 8'h03);
    wr(8'h05, 8'h02);
    wr(8'h04, 8'h10);
    settle();
    rd(8'h10, 8'h02);
    chk("flag", 8'h02, {6'h00, cmp_irq_flag_o});
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h02, 8'(c));
      rd(8'h02, 8'(c));
      chk("nmux", (c == 4 || c == 5) ? 8'h00 : 8'h01 << c, nmux_o[7:0]);
    end
    wr(8'h02, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h03, 8'(c));
      rd(8'h03, 8'(c));
      chk("pmux", (c > 1 && c < 5) ? 8'h00 : 8'h01 << c, pmux_o[7:0]);
    end
    test_done();
  end
endmodule // analog_comparator_control_tb

bind analog_comparator_control analog_comparator_control_checker
  analog_comparator_control_checker_inst (.clock_i, .rst_i, .addr_i, .wdata_i, .write_i,
  .read_i, .rdata_o, .power_enable_o, .hysteresis_enable_o, .nmux_o, .pmux_o, .sleep_i,
  .conversion_start_o, .timer_reset_o, .cmp_irq_flag_o, .wake_o);

// ### verification/comparator_core_model.sv
// Purpose: Behavioural analog core that answers the block's power and mux controls.
// Assumes: above_i says the routed noninverting level beats the inverting one.
// Notes:   An unpowered or unrouted channel gives a decision that flips every cycle.
module comparator_core_model (
  // Clock
  input  wire logic        clock_i,
  // Controls from the block
  input  wire logic [1:0]  power_i,
  input  wire logic [15:0] nmux_i,
  input  wire logic [15:0] pmux_i,
  input  wire logic [1:0]  above_i,
  // Decision to the block
  output logic      [1:0]  raw_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial raw_o = 2'b00;
  // A floating decision is never left steady, so a leak through the gating shows up.
  always @(posedge clock_i)
  begin
    for (int n = 0; n < 2; n++)
      if (power_i[n] && |nmux_i[8*n+:8] && |pmux_i[8*n+:8])
        raw_o[n] <= above_i[n] && !pmux_i[8*n+7];
      else
        raw_o[n] <= ~raw_o[n];
  end
endmodule // comparator_core_model

// ### verilog/analog_comparator_control.v
// Purpose: Two-channel comparator control with register port and consumer routing.
// Assumes: All inputs synchronous to clock_i; analog core outside.
// Notes:   Extra registers hold interrupt flags and enables.
//
// Operation
// - Inverting select decodes ground, reference, pins.
// - Noninverting select decodes ground, reference, DAC, pins.
// - Enable bit powers the comparator on.
// - Result bit reads the polarity-adjusted comparison.
// - Invert bit flips result, pin, consumers.
// - Hysteresis bit drives analog hysteresis enable.
// - Sync mode updates output on timer falling edge.
// - Rise enable lets rising edges set flag.
// - Fall enable lets falling edges set flag.
// - Two channels; mirror register shows both.
// - Active result with shutdown enable suspends generator.
// - Selected comparator rise starts a conversion.
// - Selected comparator rise resets a timer.
// - Sleep keeps comparing; stopped timer freezes sync.
// - Enabled flag wakes device from sleep.
// - Software clears flag; concurrent edge keeps it.
// - Invert or enable toggles count as edges.
// - Internal result registered once per instruction.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`include "cmp_regs.vh"
module analog_comparator_control #(
  parameter CHANNELS = 2,
  parameter TICK_DIV = 4
) (
  // Clock and reset
  input  wire                   clock_i,
  input  wire                   rst_i,
  // Register port
  input  wire [7:0]             addr_i,
  input  wire [7:0]             wdata_i,
  input  wire                   write_i,
  input  wire                   read_i,
  output reg  [7:0]             rdata_o,
  // Analog core
  input  wire [1:0]             raw_i,
  output reg  [1:0]             power_enable_o,
  output reg  [1:0]             hysteresis_enable_o,
  output reg  [15:0]            nmux_o,
  output reg  [15:0]            pmux_o,
  // Timer and system
  input  wire                   timer_clk_i,
  input  wire                   timer_runs_in_sleep_i,
  input  wire                   sleep_i,
  // Consumers
  input  wire [1:0]             shutdown_source_enable_i,
  input  wire [1:0]             conversion_trigger_select_i,
  input  wire [1:0]             timer_reset_select_i,
  output reg  [1:0]             pin_out_o,
  output reg                    shutdown_o,
  output reg                    conversion_start_o,
  output reg                    timer_reset_o,
  output reg  [1:0]             cmp_irq_flag_o,
  output reg                    wake_o
);
  // ----------------------------------------------------------------
  // Instruction-cycle tick
  // ----------------------------------------------------------------
  localparam [3:0] TICK_LAST = TICK_DIV - 1;
  reg  [3:0] div_cnt;
  wire       instr_tick = (div_cnt == TICK_LAST);
  always @(posedge clock_i)
  begin
    if (rst_i)
      div_cnt <= 4'h0;
    else if (instr_tick)
      div_cnt <= 4'h0;
    else
      div_cnt <= div_cnt + 4'h1;
  end

  // ----------------------------------------------------------------
  // Timer clock falling edge
  // ----------------------------------------------------------------
  reg  timer_clk_d;
  wire timer_fall = timer_clk_d & ~timer_clk_i;
  // System-clocked timers stop in sleep, freezing the sync latch.
  wire timer_run  = ~sleep_i | timer_runs_in_sleep_i;
  always @(posedge clock_i)
  begin
    if (rst_i)
      timer_clk_d <= 1'b0;
    else
      timer_clk_d <= timer_clk_i;
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [1:0] en_bit;
  reg  [1:0] inv_bit;
  reg  [1:0] hys_bit;
  reg  [1:0] sync_bit;
  reg  [1:0] rise_en;
  reg  [1:0] fall_en;
  reg  [5:0] nsel;
  reg  [5:0] psel;
  reg  [1:0] irq_en;
  wire [1:0] result;
  wire [1:0] sync_out;
  wire [1:0] flag;
  wire [1:0] rise_p;
  wire [15:0] nmux;
  wire [15:0] pmux;
  wire [1:0] conn;
  wire       flags_write = write_i & (addr_i == `CMP_OFF_FLAGS);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : ch
      localparam [7:0] base = `CMP_CH_STRIDE * g;
      always @(posedge clock_i)
      begin
        if (rst_i)
        begin
          en_bit[g]       <= 1'b0;
          inv_bit[g]      <= 1'b0;
          hys_bit[g]      <= 1'b0;
          sync_bit[g]     <= 1'b0;
          rise_en[g]      <= 1'b0;
          fall_en[g]      <= 1'b0;
          nsel[3*g +: 3]  <= `CMP_SEL_RESET;
          psel[3*g +: 3]  <= `CMP_SEL_RESET;
        end
        else if (write_i)
        begin
          if (addr_i == base + `CMP_OFF_MAIN)
          begin
            en_bit[g]   <= wdata_i[`CMP_BIT_ENABLE];
            inv_bit[g]  <= wdata_i[`CMP_BIT_INVERT];
            hys_bit[g]  <= wdata_i[`CMP_BIT_HYST];
            sync_bit[g] <= wdata_i[`CMP_BIT_SYNC];
          end
          if (addr_i == base + `CMP_OFF_EDGE)
          begin
            rise_en[g] <= wdata_i[`CMP_BIT_RISE];
            fall_en[g] <= wdata_i[`CMP_BIT_FALL];
          end
          if (addr_i == base + `CMP_OFF_NSEL)
            nsel[3*g +: 3] <= wdata_i[2:0];
          if (addr_i == base + `CMP_OFF_PSEL)
            psel[3*g +: 3] <= wdata_i[2:0];
        end
      end

      cmp_input_decode u_dec (
        .nsel_i      (nsel[3*g +: 3]),
        .psel_i      (psel[3*g +: 3]),
        .nmux_o      (nmux[8*g +: 8]),
        .pmux_o      (pmux[8*g +: 8]),
        .connected_o (conn[g])
      );

      cmp_channel u_ch (
        .clock_i           (clock_i),
        .rst_i             (rst_i),
        .enable_i          (en_bit[g]),
        .connected_i       (conn[g]),
        .output_invert_i   (inv_bit[g]),
        .sync_mode_i       (sync_bit[g]),
        .rise_irq_enable_i (rise_en[g]),
        .fall_irq_enable_i (fall_en[g]),
        .instr_tick_i      (instr_tick),
        .timer_fall_i      (timer_fall),
        .timer_run_i       (timer_run),
        .flag_clear_i      (flags_write & wdata_i[g]),
        .raw_i             (raw_i[g]),
        .polar_o           (),
        .result_o          (result[g]),
        .sync_o            (sync_out[g]),
        .flag_o            (flag[g]),
        .rise_pulse_o      (rise_p[g])
      );
    end
  endgenerate

  always @(posedge clock_i)
  begin
    if (rst_i)
      irq_en <= 2'b00;
    else if (write_i && addr_i == `CMP_OFF_IRQEN)
      irq_en <= wdata_i[1:0];
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;
  integer   i;
  always @*
  begin
    next_rdata = 8'h00;
    for (i = 0; i < CHANNELS; i = i + 1)
    begin
      if (addr_i == `CMP_CH_STRIDE * i + `CMP_OFF_MAIN)
        next_rdata = {en_bit[i], result[i], 1'b0, inv_bit[i], 1'b0, 1'b1,
                      hys_bit[i], sync_bit[i]};
      if (addr_i == `CMP_CH_STRIDE * i + `CMP_OFF_EDGE)
        next_rdata = {6'h00, rise_en[i], fall_en[i]};
      if (addr_i == `CMP_CH_STRIDE * i + `CMP_OFF_NSEL)
        next_rdata = {5'h00, nsel[3*i +: 3]};
      if (addr_i == `CMP_CH_STRIDE * i + `CMP_OFF_PSEL)
        next_rdata = {5'h00, psel[3*i +: 3]};
    end
    if (addr_i == `CMP_OFF_MIRROR)
      next_rdata = {6'h00, result[1], result[0]};
    if (addr_i == `CMP_OFF_FLAGS)
      next_rdata = {6'h00, flag};
    if (addr_i == `CMP_OFF_IRQEN)
      next_rdata = {6'h00, irq_en};
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rdata_o             <= 8'h00;
      power_enable_o      <= 2'b00;
      hysteresis_enable_o <= 2'b00;
      nmux_o              <= 16'h0000;
      pmux_o              <= 16'h0000;
      pin_out_o           <= 2'b00;
      shutdown_o          <= 1'b0;
      conversion_start_o  <= 1'b0;
      timer_reset_o       <= 1'b0;
      cmp_irq_flag_o      <= 2'b00;
      wake_o              <= 1'b0;
    end
    else
    begin
      rdata_o             <= read_i ? next_rdata : 8'h00;
      power_enable_o      <= en_bit;
      hysteresis_enable_o <= hys_bit;
      // Inputs are disconnected while the channel is off.
      nmux_o              <= nmux & {{8{en_bit[1]}}, {8{en_bit[0]}}};
      pmux_o              <= pmux & {{8{en_bit[1]}}, {8{en_bit[0]}}};
      pin_out_o           <= sync_out;
      shutdown_o          <= |(sync_out & shutdown_source_enable_i);
      conversion_start_o  <= |(rise_p & conversion_trigger_select_i);
      timer_reset_o       <= |(rise_p & timer_reset_select_i);
      cmp_irq_flag_o      <= flag;
      wake_o              <= sleep_i & |(flag & irq_en);
    end
  end
endmodule // analog_comparator_control

// ### verilog/cmp_channel.v
// Purpose: One comparator channel: polarity, qualification, sync latch and edge flag.
// Assumes: Raw decision synchronous to clock_i; timer clock is a level input.
// Notes:   Flag set wins over a same-cycle clear.
module cmp_channel (
  // Clock and reset
  input  wire clock_i,
  input  wire rst_i,
  // Controls
  input  wire enable_i,
  input  wire connected_i,
  input  wire output_invert_i,
  input  wire sync_mode_i,
  input  wire rise_irq_enable_i,
  input  wire fall_irq_enable_i,
  input  wire instr_tick_i,
  input  wire timer_fall_i,
  input  wire timer_run_i,
  input  wire flag_clear_i,
  input  wire raw_i,
  // Results
  output wire polar_o,
  output reg  result_o,
  output reg  sync_o,
  output reg  flag_o,
  output reg  rise_pulse_o
);
  // Disabled or unconnected channel reads as zero before inversion.
  wire qual = enable_i & connected_i & raw_i;
  assign polar_o = qual ^ output_invert_i;
  reg  prev;
  wire next_result = instr_tick_i ? polar_o : result_o;
  wire rise = next_result & ~prev;
  wire fall = ~next_result & prev;
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      result_o     <= 1'b0;
      prev         <= 1'b0;
      sync_o       <= 1'b0;
      flag_o       <= 1'b0;
      rise_pulse_o <= 1'b0;
    end
    else
    begin
      result_o     <= next_result;
      prev         <= next_result;
      rise_pulse_o <= rise;
      if (sync_mode_i)
      begin
        if (timer_fall_i & timer_run_i)
          sync_o <= polar_o;
      end
      else
        sync_o <= polar_o;
      // Invert and enable toggles move polar_o, so they count as edges too.
      if ((rise & rise_irq_enable_i) | (fall & fall_irq_enable_i))
        flag_o <= 1'b1;
      else if (flag_clear_i)
        flag_o <= 1'b0;
    end
  end
endmodule // cmp_channel

// ### verilog/cmp_input_decode.v
// Purpose: Decodes the two input select codes of one channel into mux enables.
// Assumes: One-hot outputs feed the analog input mux.
// Notes:   A no-connect code drives the connected flag low.
`include "cmp_regs.vh"
module cmp_input_decode (
  // Select codes
  input  wire [2:0] nsel_i,
  input  wire [2:0] psel_i,
  // Mux enables
  output reg  [7:0] nmux_o,
  output reg  [7:0] pmux_o,
  output reg        connected_o
);
  reg n_ok;
  reg p_ok;
  always @*
  begin
    nmux_o = 8'h00;
    pmux_o = 8'h00;
    n_ok   = 1'b1;
    p_ok   = 1'b1;
    // Codes 3..0 pick external pins 3..0; 6 fixed reference; 7 ground.
    case (nsel_i)
      `CMP_NSEL_NC_HI,
      `CMP_NSEL_NC_LO: n_ok = 1'b0;
      default:         nmux_o[nsel_i] = 1'b1;
    endcase
    case (psel_i)
      `CMP_PSEL_GND,
      `CMP_PSEL_FIXREF,
      `CMP_PSEL_DAC,
      `CMP_PSEL_PIN1,
      `CMP_PSEL_PIN0: pmux_o[psel_i] = 1'b1;
      default:        p_ok = 1'b0;
    endcase
    connected_o = n_ok & p_ok;
  end
endmodule // cmp_input_decode
